// file: include/hbp_regs.vh
`ifndef HBP_REGS_VH
`define HBP_REGS_VH

// clock period in ns
`define HBP_CLK_PERIOD_NS     20
// bootstrap release window, ns
`define HBP_BOOT_WIN_NS       20000
`define HBP_BOOT_WIN_CYC      ((`HBP_BOOT_WIN_NS) / (`HBP_CLK_PERIOD_NS))
// transient hold-off on the high side, ns
`define HBP_NEG_HOLD_NS       4500
`define HBP_NEG_HOLD_CYC      ((`HBP_NEG_HOLD_NS) / (`HBP_CLK_PERIOD_NS))
// least transient length that counts, ns (least time: rounded up)
`define HBP_NEG_MIN_NS        50
`define HBP_NEG_MIN_CYC       (((`HBP_NEG_MIN_NS) + (`HBP_CLK_PERIOD_NS) - 1) / (`HBP_CLK_PERIOD_NS))
// default minimum gap between the two gates, ns
`define HBP_MIN_GAP_NS        500
`define HBP_MIN_GAP_CYC       (((`HBP_MIN_GAP_NS) + (`HBP_CLK_PERIOD_NS) - 1) / (`HBP_CLK_PERIOD_NS))

`endif

// file: src/hbp_core.v
// Behaviour
// [RULE1] After reset both gates stay off until both supplies report above their rising thresholds.
// [RULE2] A logic-supply undervoltage during operation forces both gates off.
// [RULE3] A logic-supply undervoltage drives the active-low fault output low.
// [RULE4] A floating-supply undervoltage forces only the high gate off.
// [RULE5] The two gates are never on at the same time.
// [RULE6] The bootstrap switch is off whenever the high gate is on or the floating level is high.
// [RULE7] The bootstrap switch is on while the low gate is on and the floating level is low.
// [RULE8] After a low-side release with both gates off it turns on if the level drops within a fixed 20 us.
// [RULE9] After a high-side release with both gates off it turns on if the level drops within 20 us; the code sets no limit and turns on whenever it drops.
// [RULE10] In the high-side release case the window counter is held cleared while the level is high.
// [RULE11] A negative switch-node transient longer than 50 ns holds the high gate off for 4.5 us.
// [RULE12] The high gate follows its command and the low gate is the inverse of its active-low command.
// [RULE13] A minimum gap with both gates off is inserted when the commanded gap is shorter.
// [RULE14] Comparator flags are synchronous inputs and windows are counted on the clock.
`include "hbp_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module hbp_core #(
    parameter BOOT_WIN_CYC = `HBP_BOOT_WIN_CYC,
    parameter NEG_HOLD_CYC = `HBP_NEG_HOLD_CYC,
    parameter NEG_MIN_CYC  = `HBP_NEG_MIN_CYC,
    parameter MIN_GAP_CYC  = `HBP_MIN_GAP_CYC,
    parameter CW           = 16
) (
    input  wire clk,
    input  wire rst,
    input  wire high_side_cmd,
    input  wire low_side_cmd_n,
    input  wire logic_supply_ok,
    input  wire floating_supply_ok,
    input  wire floating_supply_level_high,
    input  wire neg_transient,
    output reg  high_gate_out,
    output reg  low_gate_out,
    output reg  fault_n,
    output reg  boot_fet_en
);

////////////////////////////////////////////////////////////////////////////////
// supply lockout

    reg          armed_q;    // both supplies good since reset or the last logic-supply undervoltage
    wire         hs_cmd_lo;
    wire         ls_cmd;
    wire         hs_allow;
    wire         ls_allow;

    // the lockout re-arms on its own once both supplies are good again,
    // so a brief logic-supply dip needs no reset from the controller
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            armed_q <= 1'b0;
        end else if (!logic_supply_ok) begin
            armed_q <= 1'b0;                                  // [RULE2]
        end else if (floating_supply_ok) begin
            armed_q <= 1'b1;                                  // [RULE1]
        end
    end

    assign ls_cmd   = ~low_side_cmd_n;                        // [RULE12]
    assign hs_allow = armed_q & logic_supply_ok & floating_supply_ok; // [RULE4]
    assign ls_allow = armed_q & logic_supply_ok;              // [RULE2]

////////////////////////////////////////////////////////////////////////////////
// negative transient filter and hold-off

    reg [CW-1:0] neg_len_q;
    reg [CW-1:0] neg_hold_q;
    wire         neg_hit;

    // a transient only counts once it has outlasted the minimum length
    assign neg_hit = neg_transient && (neg_len_q >= NEG_MIN_CYC[CW-1:0]); // [RULE11]

    // length counter stops at the threshold so it cannot wrap on a long dip
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            neg_len_q <= {CW{1'b0}};
        end else if (!neg_transient) begin
            neg_len_q <= {CW{1'b0}};
        end else if (!neg_hit) begin
            neg_len_q <= neg_len_q + 1'b1;                    // [RULE14]
        end
    end

    // hold-off restarts for as long as the transient lasts
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            neg_hold_q <= {CW{1'b0}};
        end else if (neg_hit) begin
            neg_hold_q <= NEG_HOLD_CYC[CW-1:0];               // [RULE11]
        end else if (neg_hold_q != {CW{1'b0}}) begin
            neg_hold_q <= neg_hold_q - 1'b1;                  // [RULE14]
        end
    end

    assign hs_cmd_lo = high_side_cmd & hs_allow & ~neg_hit & (neg_hold_q == {CW{1'b0}});

////////////////////////////////////////////////////////////////////////////////
// cross-conduction and minimum gap

    reg [CW-1:0] gap_q;       // cycles since both gates went off
    wire         gap_done;
    reg          hg_d;
    reg          lg_d;

    assign gap_done = (gap_q >= MIN_GAP_CYC[CW-1:0]);

    always @* begin
        hg_d = 1'b0;
        lg_d = 1'b0;
        // a gate already on stays on while commanded; the other waits its turn
        if (high_gate_out) begin
            hg_d = hs_cmd_lo;
        end else if (low_gate_out) begin
            lg_d = ls_cmd & ls_allow;
        end else if (gap_done && !(hs_cmd_lo && ls_cmd)) begin
            hg_d = hs_cmd_lo;                                 // [RULE5]
            lg_d = ls_cmd & ls_allow;                         // [RULE13]
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            high_gate_out <= 1'b0;
            low_gate_out  <= 1'b0;
        end else begin
            high_gate_out <= hg_d;                            // [RULE12]
            low_gate_out  <= lg_d;                            // [RULE12]
        end
    end

    // fault mirrors the logic supply with no latch; the controller sees it clear by itself
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_n <= 1'b1;
        end else begin
            fault_n <= logic_supply_ok;                       // [RULE3]
        end
    end

    // gap counter saturates at the minimum so longer commanded gaps pass unchanged
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_q <= {CW{1'b0}};
        end else if (high_gate_out || low_gate_out) begin
            gap_q <= {CW{1'b0}};
        end else if (!gap_done) begin
            gap_q <= gap_q + 1'b1;                            // [RULE13]
        end
    end

////////////////////////////////////////////////////////////////////////////////
// bootstrap switch

    localparam ST_IDLE = 2'd0;
    localparam ST_LWIN = 2'd1;   // fixed window after low-side release
    localparam ST_HWIN = 2'd2;   // retriggerable window after high-side release
    localparam ST_ON   = 2'd3;

    reg  [1:0]    st_q;
    reg  [1:0]    st_d;
    reg  [CW-1:0] win_q;
    reg  [CW-1:0] win_d;
    reg           hs_prev_q;
    reg           ls_prev_q;
    wire          both_off;
    wire          win_end;
    wire          ls_release;
    wire          hs_release;

    assign both_off   = ~hg_d & ~lg_d;
    assign win_end    = (win_q >= BOOT_WIN_CYC[CW-1:0]);
    assign ls_release = both_off & ls_prev_q & ~ls_cmd;
    assign hs_release = both_off & hs_prev_q & ~high_side_cmd;

    // the release edges are looked at before the level, so a release with the
    // level still high opens a window instead of being lost
    always @* begin
        st_d  = st_q;
        win_d = win_q;
        if (hg_d) begin
            st_d  = ST_IDLE;                                  // [RULE6]
            win_d = {CW{1'b0}};
        end else if (lg_d) begin
            st_d  = ST_ON;                                    // [RULE7]
            win_d = {CW{1'b0}};
        end else if (ls_release) begin
            st_d  = floating_supply_level_high ? ST_LWIN : ST_ON; // [RULE8]
            win_d = {CW{1'b0}};
        end else if (hs_release) begin
            st_d  = floating_supply_level_high ? ST_HWIN : ST_ON; // [RULE9]
            win_d = {CW{1'b0}};
        end else begin
            case (st_q)
                ST_IDLE: begin
                    st_d  = ST_IDLE;
                    win_d = {CW{1'b0}};
                end
                ST_LWIN: begin
                    if (!floating_supply_level_high) begin
                        st_d  = ST_ON;                        // [RULE8]
                        win_d = {CW{1'b0}};
                    end else if (win_end) begin
                        // fixed window: the level never restarts it
                        st_d  = ST_IDLE;
                        win_d = {CW{1'b0}};
                    end else begin
                        win_d = win_q + 1'b1;                 // [RULE14]
                    end
                end
                ST_HWIN: begin
                    if (floating_supply_level_high) begin
                        win_d = {CW{1'b0}};                   // [RULE10]
                    end else if (win_end) begin
                        st_d = ST_IDLE;
                    end else begin
                        st_d = ST_ON;                         // [RULE9]
                    end
                end
                ST_ON: begin
                    // with both gates off a high level ends the on phase
                    if (floating_supply_level_high) begin
                        st_d  = ST_IDLE;                      // [RULE6]
                        win_d = {CW{1'b0}};
                    end
                end
                default: begin
                    st_d  = ST_IDLE;
                    win_d = {CW{1'b0}};
                end
            endcase
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q  <= ST_IDLE;
            win_q <= {CW{1'b0}};
        end else begin
            st_q  <= st_d;
            win_q <= win_d;
        end
    end

    // history resets to the idle commands so no false release follows reset
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            hs_prev_q <= 1'b0;
            ls_prev_q <= 1'b0;
        end else begin
            hs_prev_q <= high_side_cmd;
            ls_prev_q <= ls_cmd;
        end
    end

    // off at once with the high gate or a high floating level
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            boot_fet_en <= 1'b0;
        end else begin
            boot_fet_en <= (st_d == ST_ON) & ~hg_d & ~floating_supply_level_high; // [RULE6]
        end
    end

endmodule // hbp_core

`default_nettype wire

// file: bench/hbp_core_sva.sv
`timescale 1ns/100ps
`default_nettype none
module hbp_core_sva #(parameter BOOT_WIN_CYC = 20, NEG_HOLD_CYC = 10, NEG_MIN_CYC = 3,
    MIN_GAP_CYC = 4, CW = 16) (
    input wire logic clk, rst, high_side_cmd, low_side_cmd_n, logic_supply_ok,
    input wire logic floating_supply_ok, floating_supply_level_high, neg_transient,
    input wire logic high_gate_out, low_gate_out, fault_n, boot_fet_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_long_dip; neg_transient[*4]; endsequence
    chk_no_overlap: assert property (!(high_gate_out && low_gate_out)) else $error("overlap");
    chk_logic_uv: assert property (!logic_supply_ok |=> !high_gate_out && !low_gate_out)
        else $error("gate on in logic uv");
    chk_fault_low: assert property (!logic_supply_ok |=> !fault_n) else $error("no fault");
    chk_float_uv: assert property (!floating_supply_ok |=> !high_gate_out) else $error("hs on");
    chk_boot_hs: assert property (high_gate_out |-> !boot_fet_en) else $error("boot hs");
    chk_boot_lvl: assert property (floating_supply_level_high |=> !boot_fet_en)
        else $error("boot lvl");
    chk_boot_ls: assert property (low_gate_out && !$past(floating_supply_level_high) |-> boot_fet_en)
        else $error("boot off with ls");
    chk_dip_hold: assert property (s_long_dip |=> !high_gate_out[*8]) else $error("hold");
    chk_hs_follow: assert property ($rose(high_gate_out) |-> $past(high_side_cmd))
        else $error("hs cause");
    chk_min_gap: assert property ($fell(low_gate_out) |-> !high_gate_out[*4]) else $error("gap");
endmodule // hbp_core_sva
bind hbp_core hbp_core_sva #(.BOOT_WIN_CYC(BOOT_WIN_CYC), .NEG_HOLD_CYC(NEG_HOLD_CYC),
    .NEG_MIN_CYC(NEG_MIN_CYC), .MIN_GAP_CYC(MIN_GAP_CYC), .CW(CW)) u_chk (.clk(clk),
    .rst(rst), .high_side_cmd(high_side_cmd), .low_side_cmd_n(low_side_cmd_n),
    .logic_supply_ok(logic_supply_ok), .floating_supply_ok(floating_supply_ok),
    .floating_supply_level_high(floating_supply_level_high), .neg_transient(neg_transient),
    .high_gate_out(high_gate_out), .low_gate_out(low_gate_out), .fault_n(fault_n),
    .boot_fet_en(boot_fet_en));
`default_nettype wire

// file: bench/hbp_pwm_model.sv
`timescale 1ns/100ps
`default_nettype none
// controller side: 0 idle, 1 high on, 2 low on, 3 both (illegal, checks refusal)
module hbp_pwm_model (
    input wire logic       clk,
    input wire logic [1:0] mode,
    output var logic       hi_cmd,
    output var logic       lo_cmd_n
);
    initial {hi_cmd, lo_cmd_n} = 2'h1;
    always @(posedge clk) begin
        hi_cmd <= #1 mode[0];
        lo_cmd_n <= #1 ~mode[1];
    end
endmodule // hbp_pwm_model
`default_nettype wire

// file: bench/hbp_core_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module hbp_core_tb_top;
    logic clk = 0, rst = 1, lok = 0, fok = 0, lvl = 0, neg = 0;
    logic [1:0] mode = 0;
    wire hi, lo_n, ho, lo, fn, bt;
    int n_errors = 0, n_tests = 0, cyc_n = 0;
    hbp_pwm_model u_pwm (.clk(clk), .mode(mode), .hi_cmd(hi), .lo_cmd_n(lo_n));
    hbp_core #(.BOOT_WIN_CYC(20), .NEG_HOLD_CYC(10), .NEG_MIN_CYC(3), .MIN_GAP_CYC(4)) DUT (
        .clk(clk), .rst(rst), .high_side_cmd(hi), .low_side_cmd_n(lo_n),
        .logic_supply_ok(lok), .floating_supply_ok(fok), .floating_supply_level_high(lvl),
        .neg_transient(neg), .high_gate_out(ho), .low_gate_out(lo), .fault_n(fn),
        .boot_fet_en(bt));
    initial forever #10 clk = ~clk;
    task wrap_up;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // the run needs well under 1000 cycles
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 3000) begin
            n_errors++;
            wrap_up;
        end
    end
    task chk(input logic s, input logic e);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %0t got %b exp %b", $time, s, e);
        end
    endtask
    task w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task go(input logic [1:0] m, input int n);
        mode = m;
        w(n);
    endtask
    task t_supply;
        go(2, 8); chk(lo, 0);
        lok = 1; w(8); chk(lo, 0);
        fok = 1; w(8); chk(lo, 1); chk(bt, 1);
        lok = 0; w(2); chk(lo, 0); chk(fn, 0);
        lok = 1; w(8); chk(lo, 1); chk(fn, 1);
        go(1, 8); chk(ho, 1); chk(bt, 0);
        fok = 0; w(2); chk(ho, 0);
        go(2, 8); chk(lo, 1);
        fok = 1; $display("supply test done");
    endtask
    task t_dip;
        go(1, 8); neg = 1; w(2); neg = 0; w(1); chk(ho, 1);
        neg = 1; w(4); neg = 0; w(1); chk(ho, 0);
        w(14); chk(ho, 1);
        // both requested from idle: neither may turn on
        go(0, 8); go(3, 8); chk(ho, 0); chk(lo, 0);
        $display("transient test done");
    endtask
    task t_boot;
        go(2, 8); lvl = 1; w(2); chk(bt, 0);
        go(0, 4); lvl = 0; w(2); chk(bt, 1);
        lvl = 1; go(2, 8); go(0, 30); lvl = 0; w(2); chk(bt, 0);
        lvl = 1; go(1, 8); go(0, 40); lvl = 0; w(2); chk(bt, 1);
        $display("bootstrap test done");
    endtask
    initial begin
        w(12);
        rst = 0;
        t_supply;
        t_dip;
        t_boot;
        wrap_up;
    end
endmodule // hbp_core_tb_top
`default_nettype wire
